// file: adc_scan_control.sv
// scanned control and observe signals of the converter front end
// assumes a boundary-scan register drives update/capture pulses
// Operation
// - ground input ties comparator negative to ground
// - hold low tracks, high freezes; idle 1
// - three-bit negative input selector, idle zero
// - pass gate control enables bypass; idle 1
// - precharge while low-active control is 0
// - supply reference select; idle 0
// - dummy conversion of ten compares on power-on
// - power-on control powers converter; idle 0
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module adc_scan_control #(
    parameter int CMP_CYCLES = adc_scan_pkg::CMP_CYCLES,
    parameter int COMPARES = adc_scan_pkg::DUMMY_COMPARES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [31:0] regRdData_q,
    // boundary-scan strobes
    input wire logic scanUpdate,
    input wire logic scanCapture,
    // analog core
    input wire logic comparatorOut,
    output logic neg_input_ground_en_q,
    output logic holdCtl_q,
    output logic [2:0] negative_input_select_q,
    output logic gain_pass_gate_en_q,
    output logic latch_precharge_n_q,
    output logic supply_reference_select_q,
    output logic converter_power_on_q,
    output logic gainClk_q,
    output logic [7:0] channel_select_q,
    output logic [9:0] dacCode_q
);
    // -------------------------------------------------------------
    // decode
    // -------------------------------------------------------------
    logic [17:0] ctrlShadow_q;
    logic [9:0] dacShadow_q;
    logic compObs_q;
    logic holdErr_q;
    logic dacErr_q;
    logic convBusy;
    logic convDone;
    logic convReady_q;
    wire wrCtrl = regWrite && regAddr == adc_scan_pkg::OFF_CTRL;
    wire wrDac = regWrite && regAddr == adc_scan_pkg::OFF_DAC;
    wire wrAct = regWrite && regAddr == adc_scan_pkg::OFF_ACTION;
    wire wrStat = regWrite && regAddr == adc_scan_pkg::OFF_STATUS;
    wire updateFire = scanUpdate || (wrAct && regWrData[adc_scan_pkg::ACT_UPDATE]);
    wire captureFire = scanCapture || (wrAct && regWrData[adc_scan_pkg::ACT_CAPTURE]);
    wire newHold = ctrlShadow_q[adc_scan_pkg::CTL_HOLD];
    wire newPower = ctrlShadow_q[adc_scan_pkg::CTL_POWER];
    // gain stages count as in use while the bypass gate is off and the new gain clock bit is 0
    wire holdBadEdge = updateFire && newHold && !holdCtl_q && !gain_pass_gate_en_q
        && !ctrlShadow_q[adc_scan_pkg::CTL_GAINCLK];
    wire dacOffMid = !holdCtl_q && dacCode_q != adc_scan_pkg::DAC_MID;
    // contention only reported, the analog side cannot be protected here
    wire contention = neg_input_ground_en_q && (negative_input_select_q != 3'h0);
    wire powerRise = updateFire && newPower && !converter_power_on_q;
    wire [31:0] statusWord = {26'h0, contention, dacErr_q, holdErr_q, convBusy,
        convReady_q, compObs_q};
    wire [31:0] rdMux = regAddr == adc_scan_pkg::OFF_CTRL ? {14'h0, ctrlShadow_q} :
        regAddr == adc_scan_pkg::OFF_DAC ? {22'h0, dacShadow_q} :
        regAddr == adc_scan_pkg::OFF_STATUS ? statusWord : 32'h0;

    // -------------------------------------------------------------
    // shadow registers and read port
    // -------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrlShadow_q <= adc_scan_pkg::CTRL_IDLE;
            dacShadow_q <= adc_scan_pkg::DAC_IDLE;
            regRdData_q <= 32'h0;
        end else begin
            if (wrCtrl) ctrlShadow_q <= regWrData[17:0];
            if (wrDac) dacShadow_q <= regWrData[9:0];
            regRdData_q <= regRead ? rdMux : 32'h0;
        end
    end

    // -------------------------------------------------------------
    // update stage: analog controls move only here
    // -------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            neg_input_ground_en_q <= 1'b0;
            holdCtl_q <= 1'b1;
            negative_input_select_q <= 3'h0;
            gain_pass_gate_en_q <= 1'b1;
            latch_precharge_n_q <= 1'b1;
            supply_reference_select_q <= 1'b0;
            converter_power_on_q <= 1'b0;
            gainClk_q <= 1'b0;
            channel_select_q <= 8'h01;
            dacCode_q <= adc_scan_pkg::DAC_IDLE;
        end else if (updateFire) begin
            neg_input_ground_en_q <= ctrlShadow_q[adc_scan_pkg::CTL_GROUND];
            holdCtl_q <= newHold;
            negative_input_select_q <= ctrlShadow_q[adc_scan_pkg::CTL_NEGATIVE_INPUT_SELECT_HI:
                adc_scan_pkg::CTL_NEGATIVE_INPUT_SELECT_LO];
            gain_pass_gate_en_q <= ctrlShadow_q[adc_scan_pkg::CTL_PASS];
            latch_precharge_n_q <= ctrlShadow_q[adc_scan_pkg::CTL_LATCH_PRECHARGE_N_N];
            supply_reference_select_q <= ctrlShadow_q[adc_scan_pkg::CTL_SUPPLY];
            converter_power_on_q <= newPower;
            gainClk_q <= ctrlShadow_q[adc_scan_pkg::CTL_GAINCLK];
            channel_select_q <= ctrlShadow_q[adc_scan_pkg::CTL_CHSEL_HI:
                adc_scan_pkg::CTL_CHSEL_LO];
            dacCode_q <= dacShadow_q;
        end
    end

    // -------------------------------------------------------------
    // observe stage and status flags (set wins over clear)
    // -------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            compObs_q <= 1'b0;
            holdErr_q <= 1'b0;
            dacErr_q <= 1'b0;
            convReady_q <= 1'b0;
        end else begin
            if (captureFire) compObs_q <= comparatorOut;
            holdErr_q <= holdBadEdge || (holdErr_q && !(wrStat &&
                regWrData[adc_scan_pkg::ST_HOLD_ERR]));
            dacErr_q <= dacOffMid || (dacErr_q && !(wrStat &&
                regWrData[adc_scan_pkg::ST_DAC_ERR]));
            // results count only after the dummy run completes
            convReady_q <= converter_power_on_q && (convDone || (convReady_q && !powerRise));
        end
    end

    // -------------------------------------------------------------
    // dummy conversion
    // -------------------------------------------------------------
    dummy_conv_seq #(
        .CYCLES(CMP_CYCLES),
        .COMPARES(COMPARES)
    ) dummyRun (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(powerRise),
        .abort(updateFire && !newPower),
        .busy_q(convBusy),
        .done_q(convDone)
    );

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    localparam int RUN_MAX = 600;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_powerUp;
        updateFire && newPower && !converter_power_on_q;
    endsequence
    sequence s_dummyDone;
        convBusy [*8] ##[1:RUN_MAX] convDone;
    endsequence

    a_ground_follow: assert property (
        updateFire |=> neg_input_ground_en_q == $past(ctrlShadow_q[0]))
        else $error("ground control missed update");
    a_hold_stable: assert property (
        !updateFire |=> $stable(holdCtl_q))
        else $error("hold moved without update");
    a_negative_input_select_load: assert property (
        updateFire |=> negative_input_select_q == $past(ctrlShadow_q[4:2]))
        else $error("negative select wrong");
    a_pass_gate: assert property (
        updateFire |=> gain_pass_gate_en_q == $past(ctrlShadow_q[5]))
        else $error("pass gate wrong");
    a_latch_precharge_n_stable: assert property (
        $changed(latch_precharge_n_q) |-> $past(updateFire))
        else $error("precharge moved without update");
    a_supply_ref: assert property (
        updateFire ##1 !updateFire |-> supply_reference_select_q == $past(ctrlShadow_q[7]))
        else $error("ref select wrong");
    a_power_dummy: assert property (
        s_powerUp ##1 (newPower && !updateFire) [*8] |-> convBusy && !convReady_q)
        else $error("dummy run not started");
    a_dummy_ends: assert property (
        s_powerUp ##1 (!updateFire throughout s_dummyDone) |=> convReady_q)
        else $error("ready not raised after dummy run");
    a_power_follow: assert property (
        updateFire |=> converter_power_on_q == $past(newPower))
        else $error("power control wrong");
    a_comp_capture: assert property (
        captureFire |=> compObs_q == $past(comparatorOut))
        else $error("comparator not captured");

    // -------------------------------------------------------------
    // flag and load checks
    // -------------------------------------------------------------
    // both flags only report, the tester has to keep hold timing and dac itself
    sequence s_badHold;
        holdBadEdge;
    endsequence
    sequence s_offMid;
        dacOffMid;
    endsequence

    a_hold_error: assert property (
        s_badHold |=> holdErr_q)
        else $error("hold timing error not flagged");
    a_dac_midpoint: assert property (
        s_offMid |=> dacErr_q)
        else $error("dac off midpoint not flagged");
    a_ready_drops: assert property (
        !converter_power_on_q |=> !convReady_q)
        else $error("ready without power");
    a_hold_load: assert property (
        updateFire |=> holdCtl_q == $past(newHold))
        else $error("hold control wrong");
    a_chsel_load: assert property (
        updateFire |=> channel_select_q == $past(ctrlShadow_q[17:10]))
        else $error("channel select wrong");
    a_dac_load: assert property (
        updateFire |=> dacCode_q == $past(dacShadow_q))
        else $error("dac code wrong");
endmodule : adc_scan_control
`default_nettype wire

// file: adc_scan_pkg.sv
// constants for the scanned converter control block
// assumes one 40 MHz clock and a plain strobe register port
package adc_scan_pkg;
    // -------------------------------------------------------------
    // register offsets
    // -------------------------------------------------------------
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_DAC = 4'h4;
    localparam logic [3:0] OFF_ACTION = 4'h8;
    localparam logic [3:0] OFF_STATUS = 4'hC;
    // -------------------------------------------------------------
    // control field positions
    // -------------------------------------------------------------
    localparam int CTL_GROUND = 0;
    localparam int CTL_HOLD = 1;
    localparam int CTL_NEGATIVE_INPUT_SELECT_LO = 2;
    localparam int CTL_NEGATIVE_INPUT_SELECT_HI = 4;
    localparam int CTL_PASS = 5;
    localparam int CTL_LATCH_PRECHARGE_N_N = 6;
    localparam int CTL_SUPPLY = 7;
    localparam int CTL_POWER = 8;
    localparam int CTL_GAINCLK = 9;
    localparam int CTL_CHSEL_LO = 10;
    localparam int CTL_CHSEL_HI = 17;
    localparam int CTL_WIDTH = 18;
    // action bits and status bits
    localparam int ACT_UPDATE = 0;
    localparam int ACT_CAPTURE = 1;
    localparam int ST_COMP = 0;
    localparam int ST_READY = 1;
    localparam int ST_BUSY = 2;
    localparam int ST_HOLD_ERR = 3;
    localparam int ST_DAC_ERR = 4;
    localparam int ST_CONTENTION = 5;
    // -------------------------------------------------------------
    // idle (reset) values
    // -------------------------------------------------------------
    localparam logic [17:0] CTRL_IDLE = 18'h00462;
    localparam logic [9:0] DAC_IDLE = 10'h200;
    localparam logic [9:0] DAC_MID = 10'h200;
    // -------------------------------------------------------------
    // timing
    // -------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;
    localparam int CMP_TIME_NS = 100;
    localparam int CMP_CYCLES = (CMP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DUMMY_COMPARES = 10;
endpackage : adc_scan_pkg

// file: dummy_conv_seq.sv
// sequencer for the dummy conversion run after power-on
// assumes start and abort are synchronous one-cycle or level inputs
`timescale 1ns/1ps
`default_nettype none
module dummy_conv_seq #(
    parameter int CYCLES = adc_scan_pkg::CMP_CYCLES,
    parameter int COMPARES = adc_scan_pkg::DUMMY_COMPARES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic start,
    input wire logic abort,
    // state
    output logic busy_q,
    output logic done_q
);
    logic [7:0] divCnt_q;
    logic [4:0] cmpCnt_q;
    wire tick = busy_q && (divCnt_q == 8'(CYCLES - 1));
    wire lastCmp = tick && (cmpCnt_q == 5'(COMPARES - 1));

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            divCnt_q <= 8'h00;
            cmpCnt_q <= 5'h00;
        end else begin
            done_q <= lastCmp && !abort;
            divCnt_q <= (tick || !busy_q) ? 8'h00 : divCnt_q + 8'h01;
            cmpCnt_q <= !busy_q ? 5'h00 : (tick ? cmpCnt_q + 5'h01 : cmpCnt_q);
            busy_q <= !abort && (start || (busy_q && !lastCmp));
        end
    end
endmodule : dummy_conv_seq
`default_nettype wire

// file: adc_core_model.sv
// behavioural sample/hold and comparator of the converter core
// assumes the block's scanned hold, power and dac outputs drive it directly
`timescale 1ns/1ps
`default_nettype none
module adc_core_model #(
    parameter logic [9:0] LEVEL = 10'h130
) (
    // clock
    input wire logic ref_clk,
    // scanned controls
    input wire logic holdCtl,
    input wire logic powerOn,
    input wire logic [9:0] dacCode,
    // observe
    output logic comparatorOut
);
    // -------------------------------------------------------------
    // analog behaviour
    // -------------------------------------------------------------
    logic [9:0] heldLevel = 10'h000;
    logic toggle = 1'b0;
    // track while hold low, freeze while high
    always @(posedge ref_clk) begin
        if (!holdCtl) begin
            heldLevel <= LEVEL;
        end
    end
    always @(posedge ref_clk) begin
        toggle <= ~toggle;
    end
    // an unpowered core gives a changing pattern, never a stale result
    assign comparatorOut = powerOn ? (dacCode > heldLevel) : toggle;
endmodule : adc_core_model
`default_nettype wire

// file: testbench.sv
// self-checking bench for the scanned converter control block
// assumes the core model stands in for the analog front end
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // -------------------------------------------------------------
    // signals
    // -------------------------------------------------------------
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWrData = 32'h0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic scanUpdate = 1'b0;
    logic scanCapture = 1'b0;
    logic comparatorOut;
    logic [31:0] regRdData_q;
    logic groundQ, holdQ, passQ, prechQ, supplyQ, powerQ, gainClkQ;
    logic [2:0] negSelQ;
    logic [7:0] chSelQ;
    logic [9:0] dacCode_q;
    wire logic [17:0] outVec = {chSelQ, gainClkQ, powerQ, supplyQ, prechQ, passQ, negSelQ,
        holdQ, groundQ};
    int errCount = 0;
    int compares = 0;
    integer seed = 37;
    logic [31:0] expQ[$];
    logic rdPend = 1'b0;
    logic [17:0] ctrl;
    logic [17:0] prev;
    logic contExp;
    localparam int N = adc_scan_pkg::DUMMY_COMPARES * adc_scan_pkg::CMP_CYCLES;

    adc_scan_control dut_u (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData_q(regRdData_q), .scanUpdate(scanUpdate), .scanCapture(scanCapture),
        .comparatorOut(comparatorOut), .neg_input_ground_en_q(groundQ), .holdCtl_q(holdQ),
        .negative_input_select_q(negSelQ), .gain_pass_gate_en_q(passQ),
        .latch_precharge_n_q(prechQ), .supply_reference_select_q(supplyQ),
        .converter_power_on_q(powerQ), .gainClk_q(gainClkQ), .channel_select_q(chSelQ),
        .dacCode_q(dacCode_q));
    adc_core_model core_u (.ref_clk(ref_clk), .holdCtl(holdQ), .powerOn(powerQ),
        .dacCode(dacCode_q), .comparatorOut(comparatorOut));

    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    // -------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------
    task automatic printVerdict();
        if (errCount == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : printVerdict
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            errCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // every strobe task leaves a quiet cycle so no strobe is assigned twice in a step
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge ref_clk);
        regWrite <= 1'b0;
        @(posedge ref_clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        expQ.push_back(e & m);
        expQ.push_back(m);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge ref_clk);
        regRead <= 1'b0;
        @(posedge ref_clk);
    endtask : rd
    task automatic scan(input logic u, input logic c);
        scanUpdate <= u;
        scanCapture <= c;
        @(posedge ref_clk);
        scanUpdate <= 1'b0;
        scanCapture <= 1'b0;
        @(posedge ref_clk);
    endtask : scan
    // read data stand only in the cycle after the strobe
    always @(posedge ref_clk) begin
        if (rdPend) begin
            chk("read data", expQ[0], regRdData_q & expQ[1]);
            void'(expQ.pop_front());
            void'(expQ.pop_front());
        end
        rdPend <= regRead;
    end
    // -------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk("idle controls", adc_scan_pkg::CTRL_IDLE, outVec);
        chk("idle dac", adc_scan_pkg::DAC_IDLE, dacCode_q);
        rd(adc_scan_pkg::OFF_CTRL, adc_scan_pkg::CTRL_IDLE, 32'hFFFFFFFF);
        rd(adc_scan_pkg::OFF_DAC, adc_scan_pkg::DAC_IDLE, 32'hFFFFFFFF);
        rd(4'h1, 32'h0, 32'hFFFFFFFF);
        rd(adc_scan_pkg::OFF_ACTION, 32'h0, 32'hFFFFFFFF);
        prev = adc_scan_pkg::CTRL_IDLE;
        for (int i = 0; i < 6; i++) begin
            ctrl = 18'($random(seed));
            ctrl[adc_scan_pkg::CTL_POWER] = 1'b0;
            wr(adc_scan_pkg::OFF_CTRL, {14'h0, ctrl});
            chk("held controls", prev, outVec);
            if (i[0]) wr(adc_scan_pkg::OFF_ACTION, 32'h1);
            else scan(1'b1, 1'b0);
            chk("updated controls", ctrl, outVec);
            rd(adc_scan_pkg::OFF_CTRL, {14'h0, ctrl}, 32'hFFFFFFFF);
            contExp = ctrl[adc_scan_pkg::CTL_GROUND] &&
                (ctrl[adc_scan_pkg::CTL_NEGATIVE_INPUT_SELECT_HI:adc_scan_pkg::CTL_NEGATIVE_INPUT_SELECT_LO] != 3'h0);
            rd(adc_scan_pkg::OFF_STATUS, {26'h0, contExp, 5'h0}, 32'h20);
            prev = ctrl;
        end
        // limit check: power on while tracking, pass gate kept, gain stages idle
        ctrl = adc_scan_pkg::CTRL_IDLE;
        ctrl[adc_scan_pkg::CTL_CHSEL_HI:adc_scan_pkg::CTL_CHSEL_LO] = 8'h08;
        ctrl[adc_scan_pkg::CTL_POWER] = 1'b1;
        ctrl[adc_scan_pkg::CTL_HOLD] = 1'b0;
        wr(adc_scan_pkg::OFF_DAC, 32'h200);
        wr(adc_scan_pkg::OFF_CTRL, {14'h0, ctrl});
        scan(1'b1, 1'b0);
        rd(adc_scan_pkg::OFF_STATUS, 32'h4, 32'h36);
        // last busy edge of the dummy run, then the first edge with ready
        repeat (N - 4) @(posedge ref_clk);
        rd(adc_scan_pkg::OFF_STATUS, 32'h4, 32'h6);
        rd(adc_scan_pkg::OFF_STATUS, 32'h2, 32'h6);
        ctrl[adc_scan_pkg::CTL_HOLD] = 1'b1;
        wr(adc_scan_pkg::OFF_CTRL, {14'h0, ctrl});
        scan(1'b1, 1'b0);
        chk("frozen hold", 32'h1, holdQ);
        for (int k = 0; k < 2; k++) begin
            wr(adc_scan_pkg::OFF_DAC, k ? 32'h143 : 32'h123);
            scan(1'b1, 1'b0);
            chk("dac code", k ? 32'h143 : 32'h123, dacCode_q);
            if (k) wr(adc_scan_pkg::OFF_ACTION, 32'h2);
            else scan(1'b0, 1'b1);
            rd(adc_scan_pkg::OFF_STATUS, k, 32'h1);
        end
        // sticky flags: writing one clears them, a bad hold edge and an off-mid dac set them
        wr(adc_scan_pkg::OFF_STATUS, 32'h18);
        rd(adc_scan_pkg::OFF_STATUS, 32'h0, 32'h18);
        ctrl[adc_scan_pkg::CTL_PASS] = 1'b0;
        ctrl[adc_scan_pkg::CTL_HOLD] = 1'b0;
        wr(adc_scan_pkg::OFF_CTRL, {14'h0, ctrl});
        scan(1'b1, 1'b0);
        ctrl[adc_scan_pkg::CTL_HOLD] = 1'b1;
        wr(adc_scan_pkg::OFF_CTRL, {14'h0, ctrl});
        scan(1'b1, 1'b0);
        rd(adc_scan_pkg::OFF_STATUS, 32'h18, 32'h18);
        repeat (2) @(posedge ref_clk);
        printVerdict();
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        errCount++;
        printVerdict();
    end
endmodule : testbench
`default_nettype wire
